// ### design/asc_adc_ctrl.sv
/*
  Control and sample post-processing for the auxiliary converter, with an
  AXI4-Lite register slave. Assumes the analog core sits on CLK_SYS, takes a
  one-cycle start strobe and answers with a one-cycle done and its raw word.
*/
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module asc_adc_ctrl #(
  parameter int PER_M0_CYC = asc_pkg::PER_M0,
  parameter int PER_M1_CYC = asc_pkg::PER_M1,
  parameter int SET_M0_CYC = asc_pkg::SET_M0,
  parameter int SET_M1_CYC = asc_pkg::SET_M1,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [asc_pkg::ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [asc_pkg::ADDR_W-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output asc_pkg::asc_core_cfg_type CORE_CFG,
  output logic CORE_START,
  input wire logic CORE_DONE,
  input wire logic [asc_pkg::SMP_W-1:0] CORE_DATA,
  input wire logic CORE_OVR
);
  import asc_pkg::*;

  localparam int CONV_LIM = CONV_CYC + 2;

  // Bus state
  logic aw_free_r, aw_free_nxt, w_free_r, w_free_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_lane0_r, w_lane0_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Configuration and status
  logic en_r, en_nxt, ref_r, ref_nxt, tmo_r, tmo_nxt;
  logic [1:0] range_r, range_nxt;
  logic [2:0] mode_r, mode_nxt, alt_r, alt_nxt;
  logic [3:0] chan_r, chan_nxt;
  asc_core_cfg_type cfg_r, cfg_nxt;
  logic cfg_chg_r, cfg_chg_nxt;
  // Conversion sequencing
  asc_state_type state_r, state_nxt;
  logic start_r, start_nxt, stale_r, stale_nxt;
  logic wr_fire, rd_fire, cfg_wr, tmo_set, rate_load;
  logic settle_busy, rate_busy, conv_busy;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [SMP_W-1:0] fifo_out_data, smp_proc;
  logic [CNT_W-1:0] per_cur, set_cur;

  assign wr_fire = !aw_free_r && !w_free_r && !bvalid_r;
  assign rd_fire = ARVALID && arready_r;
  assign cfg_wr = wr_fire && w_lane0_r && (aw_addr_r == OFS_CTRL || aw_addr_r == OFS_CHAN);
  assign fifo_pop = rd_fire && (ARADDR == OFS_DATA) && fifo_out_valid;

  // Per-mode sample period and settling time
  always_comb begin
    per_cur = CNT_W'(PER_M4);
    set_cur = CNT_W'(SET_M4);
    case (mode_r)
      3'h0: begin
        per_cur = CNT_W'(PER_M0_CYC);
        set_cur = CNT_W'(SET_M0_CYC);
      end
      3'h1: begin
        per_cur = CNT_W'(PER_M1_CYC);
        set_cur = CNT_W'(SET_M1_CYC);
      end
      3'h2: begin
        per_cur = CNT_W'(PER_M2);
        set_cur = CNT_W'(SET_M2);
      end
      3'h3: begin
        per_cur = CNT_W'(PER_M3);
        set_cur = CNT_W'(SET_M3);
      end
      default: begin
        per_cur = CNT_W'(PER_M4);
        set_cur = CNT_W'(SET_M4);
      end
    endcase
  end

  // Bus channels, register writes and read mux
  always_comb begin
    aw_free_nxt = aw_free_r;
    aw_addr_nxt = aw_addr_r;
    w_free_nxt = w_free_r;
    w_data_nxt = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    en_nxt = en_r;
    ref_nxt = ref_r;
    range_nxt = range_r;
    mode_nxt = mode_r;
    chan_nxt = chan_r;
    alt_nxt = alt_r;
    tmo_nxt = tmo_r | tmo_set;
    if (AWVALID && aw_free_r) begin
      aw_free_nxt = 1'b0;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && w_free_r) begin
      w_free_nxt = 1'b0;
      w_data_nxt = WDATA;
      w_lane0_nxt = WSTRB[0];
    end
    if (BVALID && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // Both halves held: commit the write and answer
    if (wr_fire) begin
      aw_free_nxt = 1'b1;
      w_free_nxt = 1'b1;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (aw_addr_r)
        OFS_CTRL: begin
          if (w_lane0_r) begin
            en_nxt = w_data_r[CTRL_EN_BIT];
            ref_nxt = w_data_r[CTRL_REF_BIT];
            // Reserved codes leave the old setting in place
            if (w_data_r[CTRL_RNG_LSB +: 2] <= RANGE_MAX) begin
              range_nxt = w_data_r[CTRL_RNG_LSB +: 2];
            end
            if (w_data_r[CTRL_MODE_LSB +: 3] <= MODE_MAX) begin
              mode_nxt = w_data_r[CTRL_MODE_LSB +: 3];
            end
          end
        end
        OFS_CHAN: begin
          if (w_lane0_r && w_data_r[3:0] < NUM_CH) begin
            chan_nxt = w_data_r[3:0];
            alt_nxt = w_data_r[CHAN_ALT_LSB +: 3];
          end
        end
        OFS_STAT: begin
          // Clear by writing one; a timeout in the same cycle wins
          if (w_lane0_r && w_data_r[STAT_TMO_BIT]) begin
            tmo_nxt = tmo_set;
          end
        end
        OFS_DATA: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (RVALID && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0;
      case (ARADDR)
        OFS_CTRL: begin
          rdata_nxt[CTRL_EN_BIT] = en_r;
          rdata_nxt[CTRL_REF_BIT] = ref_r;
          rdata_nxt[CTRL_RNG_LSB +: 2] = range_r;
          rdata_nxt[CTRL_MODE_LSB +: 3] = mode_r;
        end
        OFS_CHAN: begin
          rdata_nxt[3:0] = chan_r;
          rdata_nxt[CHAN_ALT_LSB +: 3] = alt_r;
        end
        OFS_STAT: begin
          rdata_nxt[STAT_BUSY_BIT] = (state_r == ST_CONV);
          rdata_nxt[STAT_SETL_BIT] = settle_busy;
          rdata_nxt[STAT_AVAIL_BIT] = fifo_out_valid;
          rdata_nxt[STAT_TMO_BIT] = tmo_r;
        end
        OFS_DATA: begin
          // Reading pops one sample; an empty buffer reads zero
          if (fifo_out_valid) begin
            rdata_nxt[SMP_W-1:0] = fifo_out_data;
          end
        end
        default: begin
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  // Front-end settings; the alternate pin bit follows only a paired channel
  always_comb begin
    cfg_nxt.ref_sel = ref_r;
    cfg_nxt.range = range_r;
    cfg_nxt.chan = chan_r;
    case (chan_r)
      PAIR0_CH: cfg_nxt.alt = alt_r[0];
      PAIR1_CH: cfg_nxt.alt = alt_r[1];
      PAIR2_CH: cfg_nxt.alt = alt_r[2];
      default: cfg_nxt.alt = 1'b0;
    endcase
    cfg_chg_nxt = cfg_wr;
  end

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    rate_load = 1'b0;
    tmo_set = 1'b0;
    stale_nxt = stale_r | cfg_chg_r;
    case (state_r)
      ST_IDLE: begin
        // Start only with room to store, so a full buffer stalls sampling
        if (en_r && fifo_in_ready && !rate_busy && !cfg_chg_r) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
          rate_load = 1'b1;
          stale_nxt = 1'b0;
        end
      end
      ST_CONV: begin
        if (CORE_DONE) begin
          state_nxt = ST_IDLE;
        end else if (!conv_busy && !start_r) begin
          state_nxt = ST_IDLE;
          tmo_set = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Over-range raw words saturate to full scale
  assign smp_proc = CORE_OVR ? SMP_FULL : CORE_DATA;
  // Results that straddle a switch or land in settling are dropped
  assign fifo_in_valid = (state_r == ST_CONV) && CORE_DONE && !stale_r && !cfg_chg_r
                         && !settle_busy;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_free_r <= 1'b1;
      aw_addr_r <= '0;
      w_free_r <= 1'b1;
      w_data_r <= 32'h0;
      w_lane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
      en_r <= 1'b0;
      ref_r <= 1'b0;
      range_r <= 2'h0;
      mode_r <= 3'h0;
      chan_r <= 4'h0;
      alt_r <= 3'h0;
      tmo_r <= 1'b0;
      cfg_r <= '0;
      cfg_chg_r <= 1'b0;
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      stale_r <= 1'b0;
    end else begin
      aw_free_r <= aw_free_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_free_r <= w_free_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      arready_r <= arready_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      en_r <= en_nxt;
      ref_r <= ref_nxt;
      range_r <= range_nxt;
      mode_r <= mode_nxt;
      chan_r <= chan_nxt;
      alt_r <= alt_nxt;
      tmo_r <= tmo_nxt;
      cfg_r <= cfg_nxt;
      cfg_chg_r <= cfg_chg_nxt;
      state_r <= state_nxt;
      start_r <= start_nxt;
      stale_r <= stale_nxt;
    end
  end

  // Settling restarts one cycle after a write, once the new mode is in place
  asc_timer #(.W(CNT_W)) u_settle (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .load(cfg_chg_r),
    .load_val(set_cur),
    .busy(settle_busy)
  );

  asc_timer #(.W(CNT_W)) u_rate (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .load(rate_load),
    .load_val(per_cur),
    .busy(rate_busy)
  );

  asc_timer #(.W(CNT_W)) u_conv (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .load(rate_load),
    .load_val(CNT_W'(CONV_CYC)),
    .busy(conv_busy)
  );

  asc_fifo #(.W(SMP_W), .DEPTH(FIFO_DEPTH)) u_buf (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(smp_proc),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign AWREADY = aw_free_r;
  assign WREADY = w_free_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign CORE_CFG = cfg_r;
  assign CORE_START = start_r;

  // Helper counters: cycles since last start and since settling began
  logic [CNT_W-1:0] gap_r, age_r;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      gap_r <= '1;
      age_r <= '0;
    end else begin
      gap_r <= start_r ? CNT_W'(1) : ((gap_r == '1) ? gap_r : gap_r + 1'b1);
      age_r <= cfg_chg_r ? '0 : ((age_r == '1) ? age_r : age_r + 1'b1);
    end
  end

  property p_rate_cap;
    @(posedge CLK_SYS) disable iff (!NRST) start_r |-> gap_r >= CNT_W'(PER_M4);
  endproperty
  a_rate_cap: assert property (p_rate_cap) else $error("Starts closer than fastest period");

  property p_mode_period;
    @(posedge CLK_SYS) disable iff (!NRST)
      start_r && $stable(mode_r) |-> ##1 (!start_r)[*8];
  endproperty
  a_mode_period: assert property (p_mode_period) else $error("Mode period not kept");

  property p_conv_bound;
    @(posedge CLK_SYS) disable iff (!NRST) start_r |-> ##[1:CONV_LIM] (state_r == ST_IDLE);
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("Conversion ran too long");

  property p_settle_len;
    @(posedge CLK_SYS) disable iff (!NRST) $fell(settle_busy) |-> age_r == set_cur;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("Settling time wrong");

  property p_withhold;
    @(posedge CLK_SYS) disable iff (!NRST) cfg_chg_r |-> ##1 (!fifo_in_valid)[*8];
  endproperty
  a_withhold: assert property (p_withhold) else $error("Sample passed while settling");

  property p_chan_route;
    @(posedge CLK_SYS) disable iff (!NRST)
      wr_fire && w_lane0_r && aw_addr_r == OFS_CHAN && w_data_r[3:0] < NUM_CH
      |-> ##2 CORE_CFG.chan == $past(w_data_r[3:0], 2);
  endproperty
  a_chan_route: assert property (p_chan_route) else $error("Channel not routed");

  property p_pair_one;
    @(posedge CLK_SYS) disable iff (!NRST)
      CORE_CFG.chan < NUM_CH && (!CORE_CFG.alt || CORE_CFG.chan == PAIR0_CH
      || CORE_CFG.chan == PAIR1_CH || CORE_CFG.chan == PAIR2_CH);
  endproperty
  a_pair_one: assert property (p_pair_one) else $error("Illegal input selection");

  property p_ref_route;
    @(posedge CLK_SYS) disable iff (!NRST)
      wr_fire && w_lane0_r && aw_addr_r == OFS_CTRL
      |-> ##2 CORE_CFG.ref_sel == $past(w_data_r[CTRL_REF_BIT], 2);
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("Reference not routed");

  property p_range_legal;
    @(posedge CLK_SYS) disable iff (!NRST) CORE_CFG.range <= RANGE_MAX && mode_r <= MODE_MAX;
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("Range or mode illegal");

  property p_data_width;
    @(posedge CLK_SYS) disable iff (!NRST)
      fifo_pop |=> RVALID && RDATA[31:SMP_W] == '0 && RDATA[SMP_W-1:0] == $past(fifo_out_data);
  endproperty
  a_data_width: assert property (p_data_width) else $error("Sample read wrong");

  property p_processed;
    @(posedge CLK_SYS) disable iff (!NRST)
      fifo_in_valid && CORE_OVR |-> smp_proc == SMP_FULL;
  endproperty
  a_processed: assert property (p_processed) else $error("Over-range not saturated");
endmodule : asc_adc_ctrl

// ### design/asc_pkg.sv
/*
  Shared constants and types of the auxiliary converter controller.
  Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package asc_pkg;
  // Clock and widths
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int CNT_W = 14;
  localparam int SMP_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [3:0] NUM_CH = 4'h9;
  localparam logic [2:0] MODE_MAX = 3'h4;

  // Mode sample rates in Hz, least period rounded up to whole cycles
  localparam int RATE_HZ_M0 = 5859;
  localparam int RATE_HZ_M1 = 11700;
  localparam int RATE_HZ_M2 = 46875;
  localparam int RATE_HZ_M3 = 93750;
  localparam int RATE_HZ_M4 = 187000;
  localparam int PER_M0 = (CLK_HZ + RATE_HZ_M0 - 1) / RATE_HZ_M0;
  localparam int PER_M1 = (CLK_HZ + RATE_HZ_M1 - 1) / RATE_HZ_M1;
  localparam int PER_M2 = (CLK_HZ + RATE_HZ_M2 - 1) / RATE_HZ_M2;
  localparam int PER_M3 = (CLK_HZ + RATE_HZ_M3 - 1) / RATE_HZ_M3;
  localparam int PER_M4 = (CLK_HZ + RATE_HZ_M4 - 1) / RATE_HZ_M4;

  // Settling after a channel switch, in us, then cycles
  localparam int LAT_US_M0 = 171;
  localparam int LAT_US_M1 = 85;
  localparam int LAT_US_M2 = 21;
  localparam int LAT_US_M3 = 11;
  localparam int LAT_US_M4 = 5;
  localparam int SET_M0 = LAT_US_M0 * CLK_PER_US;
  localparam int SET_M1 = LAT_US_M1 * CLK_PER_US;
  localparam int SET_M2 = LAT_US_M2 * CLK_PER_US;
  localparam int SET_M3 = LAT_US_M3 * CLK_PER_US;
  localparam int SET_M4 = LAT_US_M4 * CLK_PER_US;

  // Longest conversion time, rounded down
  localparam int CONV_US = 10;
  localparam int CONV_CYC = CONV_US * CLK_PER_US;

  // Register offsets and fields
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_DATA = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REF_BIT = 1;
  localparam int CTRL_RNG_LSB = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CHAN_ALT_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SETL_BIT = 1;
  localparam int STAT_AVAIL_BIT = 2;
  localparam int STAT_TMO_BIT = 3;
  localparam logic [1:0] RANGE_MAX = 2'h2;
  localparam logic [3:0] PAIR0_CH = 4'h2;
  localparam logic [3:0] PAIR1_CH = 4'h5;
  localparam logic [3:0] PAIR2_CH = 4'h6;
  localparam logic [SMP_W-1:0] SMP_FULL = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings presented to the analog front end
  typedef struct packed {
    logic ref_sel;
    logic [1:0] range;
    logic [3:0] chan;
    logic alt;
  } asc_core_cfg_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } asc_state_type;
endpackage : asc_pkg

// ### design/asc_timer.sv
/*
  Loadable down counter; busy while the count is not zero.
  Assumes load is a single-cycle strobe from logic on the same clock.
*/
`timescale 1ns/1ps
module asc_timer #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // A reload restarts the interval even while it runs
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != '0);
endmodule : asc_timer

// ### design/asc_fifo.sv
/*
  Small ring buffer with valid/ready on both sides.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module asc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and fill count update
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; it is read only when counted valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : asc_fifo

// ### testbench/asc_core_model.sv
/*
  Behavioural analog core: answers each start strobe after a set delay, except while mute is high.
  Assumes the controller and this model share CLK_SYS.
*/
`timescale 1ns/1ps
module asc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input asc_pkg::asc_core_cfg_type cfg,
  input wire logic [9:0] dly,
  input wire logic ovr,
  input wire logic mute,
  output logic done,
  output logic [asc_pkg::SMP_W-1:0] data,
  output logic over
);
  import asc_pkg::*;
  logic [9:0] cnt;
  // Data lines toggle outside done so a stale word is never mistaken for a result
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 10'h0;
      done <= 1'b0;
      data <= 16'h0;
      over <= 1'b0;
    end else begin
      done <= 1'b0;
      data <= ~data;
      over <= ~over;
      if (start && !mute) begin
        cnt <= dly;
      end else if (cnt == 10'h1) begin
        done <= 1'b1;
        data <= {12'hc3a, cfg.chan};
        over <= ovr;
        cnt <= 10'h0;
      end else if (cnt > 10'h1) begin
        cnt <= cnt - 10'h1;
      end
    end
  end
endmodule : asc_core_model

// ### testbench/asc_adc_ctrl_test.sv
/*
  Self-checking bench: AXI4-Lite tasks and scenario sequence.
  Assumes the core model on the far side of the controller.
*/
`timescale 1ns/1ps
module asc_adc_ctrl_test;
  import asc_pkg::*;
  logic CLK_SYS = 1'h0, NRST = 1'h0, ovr = 1'h0, mute = 1'h0;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [ADDR_W-1:0] AWADDR = 4'h0, ARADDR = 4'h0;
  logic [31:0] WDATA = 32'h0, RDATA, v;
  logic [3:0] WSTRB = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CORE_START, CORE_DONE, CORE_OVR;
  logic [1:0] BRESP, RRESP, rsp;
  logic [SMP_W-1:0] CORE_DATA;
  logic [9:0] dly = 10'h28;
  asc_core_cfg_type CORE_CFG;
  int num_errors = 0, n_tests = 0, cyc = 0, last = 0, per = PER_M4, nst = 0, t0, n0;
  int pers[5] = '{300, 300, PER_M2, PER_M3, PER_M4};
  int sets[5] = '{300, 300, SET_M2, SET_M3, SET_M4};

  asc_adc_ctrl #(.PER_M0_CYC(300), .PER_M1_CYC(300), .SET_M0_CYC(300), .SET_M1_CYC(300),
    .FIFO_DEPTH(2)) i_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .CORE_CFG(CORE_CFG), .CORE_START(CORE_START), .CORE_DONE(CORE_DONE),
    .CORE_DATA(CORE_DATA), .CORE_OVR(CORE_OVR));
  asc_core_model i_core (.clk(CLK_SYS), .rst_n(NRST), .start(CORE_START), .cfg(CORE_CFG),
    .dly(dly), .ovr(ovr), .mute(mute), .done(CORE_DONE), .data(CORE_DATA), .over(CORE_OVR));

  // 50 MHz clock
  always #10 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Front-end settings are registered one edge after the write answer
  task automatic chk_cfg(input logic [31:0] e);
    @(posedge CLK_SYS);
    chk({24'h0, CORE_CFG}, e);
  endtask : chk_cfg

  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // Cycle count; start spacing must respect the active mode's period
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (CORE_START === 1'b1) begin
      nst <= nst + 1;
      if (last > 0) chk({31'h0, cyc - last >= per}, 32'h1);
      last <= cyc;
    end
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge CLK_SYS);
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge CLK_SYS);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    v = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask : rd

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] r, input logic f);
    return {25'h0, m, r, f, 1'b1};
  endfunction : ctl

  function automatic logic [31:0] cfg(input logic f, input logic [1:0] r, input logic [3:0] c,
    input logic a);
    return {24'h0, f, r, c, a};
  endfunction : cfg

  // Hang guard
  initial begin
    repeat (80000) @(posedge CLK_SYS);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge CLK_SYS);
    NRST <= 1'b1;
    chk_cfg(32'h0);
    rd(OFS_CTRL);
    chk(v, 32'h0);
    rd(OFS_STAT);
    chk(v, 32'h0);
    rd(OFS_DATA);
    chk(v, 32'h0);
    rd(4'h2);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(4'h2, 32'h1, 4'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Paired pin, then settings that must be ignored
    wr(OFS_CHAN, 32'h25, 4'h1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    wr(OFS_CTRL, ctl(3'h4, 2'h2, 1'b1), 4'hf);
    chk_cfg(cfg(1'b1, 2'h2, 4'h5, 1'b1));
    wr(OFS_CHAN, 32'h9, 4'h1);
    wr(OFS_CHAN, 32'h3, 4'h0);
    wr(OFS_CTRL, ctl(3'h5, 2'h3, 1'b1), 4'h1);
    chk_cfg(cfg(1'b1, 2'h2, 4'h5, 1'b1));
    wr(OFS_CHAN, 32'h71, 4'h1);
    for (int r = 0; r < 3; r++) begin
      wr(OFS_CTRL, ctl(3'h4, r[1:0], r[0]), 4'h1);
      chk_cfg(cfg(r[0], r[1:0], 4'h1, 1'b0));
    end
    // Every mode: settling withholds results, then rate holds
    for (int m = 0; m < 5; m++) begin
      per = PER_M4;
      wr(OFS_CTRL, ctl(m[2:0], 2'h0, 1'b0), 4'h1);
      t0 = cyc;
      rd(OFS_STAT);
      chk({31'h0, v[STAT_SETL_BIT]}, 32'h1);
      rd(OFS_DATA);
      rd(OFS_DATA);
      do rd(OFS_STAT); while (v[STAT_AVAIL_BIT] !== 1'b1);
      chk({31'h0, cyc - t0 >= sets[m]}, 32'h1);
      per = pers[m];
      rd(OFS_DATA);
      chk(v, 32'hc3a1);
      repeat (2 * pers[m]) @(posedge CLK_SYS);
    end
    // Over-range saturates; a full buffer stalls starts
    ovr <= 1'b1;
    rd(OFS_DATA);
    rd(OFS_DATA);
    n0 = nst;
    repeat (1500) @(posedge CLK_SYS);
    chk({31'h0, nst - n0 <= 3}, 32'h1);
    rd(OFS_DATA);
    chk(v, 32'hffff);
    rd(OFS_DATA);
    chk(v, 32'hffff);
    rd(OFS_DATA);
    chk(v, 32'h0);
    ovr <= 1'b0;
    // Silent core raises the sticky timeout, write one clears it
    mute <= 1'b1;
    repeat (1200) @(posedge CLK_SYS);
    mute <= 1'b0;
    rd(OFS_STAT);
    chk({31'h0, v[STAT_TMO_BIT]}, 32'h1);
    wr(OFS_STAT, 32'h8, 4'h1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(OFS_STAT);
    chk({31'h0, v[STAT_TMO_BIT]}, 32'h0);
    conclude();
  end
endmodule : asc_adc_ctrl_test
